// *** hw/isp_ctrl_pkg.sv ***
`default_nettype none
package isp_ctrl_pkg;
  localparam logic [7:0] TEST_ENABLE_OFFSET = 8'hc7;
  localparam int TEST_ENABLE_BIT = 0;
  localparam logic [7:0] TEST_ENABLE_RESET = 8'h00;
  localparam int MAP_SRAM_CODE_BIT = 0;
  localparam int MAP_PERIPH_MODE_BIT = 1;
  localparam logic [7:0] MAP_CLEAR_MASK = 8'h03;
  localparam int CLK_HZ = 100_000_000;
  localparam int RECOVERY_TIME_NS = 200;
  localparam int RECOVERY_CYCLES = (RECOVERY_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int EEPROM_BLOCK_TIME_MS = 5;
  localparam int EEPROM_BLOCK_CYCLES = EEPROM_BLOCK_TIME_MS * (CLK_HZ / 1000);
  localparam int IR_WIDTH = 8;
  localparam logic [7:0] CMD_CONFIG_ENABLE = 8'h0c;
  localparam logic [7:0] CMD_CONFIG_ENABLE_OD = 8'h0d;
  localparam logic [7:0] CMD_CONFIG_DISABLE = 8'h01;
  localparam logic [7:0] CMD_CONFIG_CLEAR = 8'h0a;
  localparam logic [7:0] CMD_BYPASS = 8'hff;
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } test_pins_t;
  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } ir_update_t;
endpackage : isp_ctrl_pkg
`default_nettype wire

// *** hw/pin_sync.sv ***
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // asynchronous in, synchronous out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_reg;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage_reg <= '0;
      sync_out <= '0;
    end else begin
      stage_reg <= async_in;
      sync_out <= stage_reg;
    end
  end
endmodule : pin_sync
`default_nettype wire

// *** hw/tap_fsm.sv ***
`default_nettype none
module tap_fsm (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // synchronised test pins and edge strobes
  input wire logic tck_rise,
  input wire logic tck_fall,
  input wire logic tms,
  input wire logic tdi,
  input wire logic port_abort,
  // outputs
  output isp_ctrl_pkg::ir_update_t ir_update,
  output logic tdo_bit,
  output logic shift_active
);
  typedef enum logic [15:0] {
    TLR = 16'h0001, RTI = 16'h0002, SDS = 16'h0004, CDR = 16'h0008,
    SDR = 16'h0010, E1D = 16'h0020, PDR = 16'h0040, E2D = 16'h0080,
    UDR = 16'h0100, SIS = 16'h0200, CIR = 16'h0400, SIR = 16'h0800,
    E1I = 16'h1000, PIR = 16'h2000, E2I = 16'h4000, UIR = 16'h8000
  } tap_state_t;
  tap_state_t state_reg, state_next;
  logic [isp_ctrl_pkg::IR_WIDTH-1:0] ir_shift_reg;
  logic dr_bypass_reg;
  always_comb begin
    unique case (state_reg)
      TLR: state_next = tms ? TLR : RTI;
      RTI: state_next = tms ? SDS : RTI;
      SDS: state_next = tms ? SIS : CDR;
      CDR: state_next = tms ? E1D : SDR;
      SDR: state_next = tms ? E1D : SDR;
      E1D: state_next = tms ? UDR : PDR;
      PDR: state_next = tms ? E2D : PDR;
      E2D: state_next = tms ? UDR : SDR;
      UDR: state_next = tms ? SDS : RTI;
      SIS: state_next = tms ? TLR : CIR;
      CIR: state_next = tms ? E1I : SIR;
      SIR: state_next = tms ? E1I : SIR;
      E1I: state_next = tms ? UIR : PIR;
      PIR: state_next = tms ? E2I : PIR;
      E2I: state_next = tms ? UIR : SIR;
      UIR: state_next = tms ? SDS : RTI;
      default: state_next = TLR;
    endcase
  end
  // states advance on test clock edges only; a port abort forces TLR on the system clock alone
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= TLR;
      ir_shift_reg <= '0;
      dr_bypass_reg <= 1'b0;
      ir_update <= '0;
    end else if (port_abort) begin
      state_reg <= TLR;
      ir_update <= '0;
    end else begin
      ir_update.valid <= 1'b0;
      if (tck_rise) begin
        state_reg <= state_next;
        if (state_reg == CIR) ir_shift_reg <= 8'h01;
        if (state_reg == SIR) ir_shift_reg <= {tdi, ir_shift_reg[7:1]};
        if (state_reg == SDR) dr_bypass_reg <= tdi;
        if (state_reg == UIR) begin
          ir_update.valid <= 1'b1;
          ir_update.code <= ir_shift_reg;
        end
      end
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tdo_bit <= 1'b0;
      shift_active <= 1'b0;
    end else if (tck_fall) begin
      tdo_bit <= (state_reg == SIR) ? ir_shift_reg[0] : dr_bypass_reg;
      shift_active <= (state_reg == SIR) || (state_reg == SDR);
    end
  end
endmodule : tap_fsm
`default_nettype wire

// *** hw/reset_isp_ctrl.sv ***
// What this block does
// - after reset rises, hold memory access off for the recovery time
// - power-on reset loads configuration, clears registers, memories to read mode
// - block EEPROM write strobes for about 5 ms after power-up
// - refuse to start flash writes while supply lockout is active
// - warm reset accepted, then same recovery time applies
// - reset sends MCU I/O to input, tri-states address, data, peripheral pins
// - logic outputs valid in warm reset, after config load in power-on
// - macrocell flops cleared by power-on, follow reset/preset equations otherwise
// - reset clears SRAM-code and peripheral-mode map bits, rest from configuration
// - test pins dedicated when dedicate bit, runtime bit or select term true
// - enabled test pins are inputs; data-out drives only after enable command
// - runtime enable bit at C7h, set by write, cleared by reset or write
// - select product term enables the test pins when true
// - blank part enables the four test pins by default
// - configuration command set only, no boundary scan
// - status and error pins active after config enable command, optional open drain
// - status pin high in read mode, low during flash or EEPROM writes
// - reset aborts test port only when enabled by the runtime bit
`default_nettype none
module reset_isp_ctrl #(
  parameter int EEPROM_BLOCK_CYCLES = isp_ctrl_pkg::EEPROM_BLOCK_CYCLES,
  parameter logic [7:0] MAP_CONFIG_VALUE = 8'h00
) (
  // clock and power-on reset
  input wire logic clk_sys,
  input wire logic rst,
  // warm reset pin, active low, asynchronous
  input wire logic warm_reset_n,
  // configuration and supply status
  input wire logic nvm_test_dedicate_bit,
  input wire logic part_blank,
  input wire logic config_loaded,
  input wire logic supply_lockout,
  input wire logic test_select_term,
  // memory activity
  input wire logic flash_write_req,
  input wire logic eeprom_write_strobe,
  input wire logic flash_busy,
  input wire logic eeprom_busy,
  input wire logic flash_error,
  input wire logic [7:0] macrocell_reset_value,
  // microcontroller register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // test pins from the cable side
  input wire logic tck_pin,
  input wire logic tms_pin,
  input wire logic tdi_pin,
  output logic tdo_out,
  output logic tdo_oe_n,
  // status and error extension pins
  output logic status_out,
  output logic status_oe_n,
  output logic error_out,
  output logic error_oe_n,
  // control towards the rest of the device
  output logic memory_access_ok,
  output logic flash_write_go,
  output logic eeprom_strobe_out,
  output logic io_force_input,
  output logic logic_outputs_valid,
  output logic test_pins_dedicated,
  output logic [7:0] macrocell_state,
  output logic [7:0] memory_map_register
);
  logic [1:0] warm_sync_reg;
  logic [2:0] pins_sync;
  logic warm_active, any_reset;
  logic [7:0] test_enable_reg;
  logic [15:0] recovery_reg;
  logic [31:0] eeblock_reg;
  logic cmd_enabled_reg, od_mode_reg, disabled_reg, error_reg, read_mode_reg;
  logic tck_prev_reg, tck_rise, tck_fall;
  logic runtime_only, port_abort, test_on;
  logic tdo_bit, shift_active;
  isp_ctrl_pkg::ir_update_t ir_update;
  isp_ctrl_pkg::test_pins_t pins;
  logic is_enable_cmd, is_od_cmd, is_disable_cmd, is_clear_cmd, reg_hit;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) warm_sync_reg <= 2'b00;
    else warm_sync_reg <= {warm_sync_reg[0], ~warm_reset_n};
  end
  assign warm_active = warm_sync_reg[1];
  assign any_reset = warm_active;
  pin_sync #(.WIDTH(3)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in({tck_pin, tms_pin, tdi_pin}),
    .sync_out(pins_sync)
  );
  assign pins = pins_sync;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) tck_prev_reg <= 1'b0;
    else tck_prev_reg <= pins.tck;
  end
  assign runtime_only = test_enable_reg[isp_ctrl_pkg::TEST_ENABLE_BIT] &&
                        !nvm_test_dedicate_bit && !test_select_term && !part_blank;
  assign port_abort = any_reset && runtime_only;
  assign test_on = nvm_test_dedicate_bit ||
                   test_enable_reg[isp_ctrl_pkg::TEST_ENABLE_BIT] ||
                   test_select_term ||
                   part_blank;
  assign tck_rise = test_on && pins.tck && !tck_prev_reg;
  assign tck_fall = test_on && !pins.tck && tck_prev_reg;
  tap_fsm u_tap (
    .clk_sys(clk_sys),
    .rst(rst),
    .tck_rise(tck_rise),
    .tck_fall(tck_fall),
    .tms(pins.tms),
    .tdi(pins.tdi),
    .port_abort(port_abort),
    .ir_update(ir_update),
    .tdo_bit(tdo_bit),
    .shift_active(shift_active)
  );
  // only configuration opcodes are decoded; anything else behaves as bypass
  assign is_enable_cmd = ir_update.valid && (ir_update.code == isp_ctrl_pkg::CMD_CONFIG_ENABLE ||
                         ir_update.code == isp_ctrl_pkg::CMD_CONFIG_ENABLE_OD);
  assign is_od_cmd = ir_update.code == isp_ctrl_pkg::CMD_CONFIG_ENABLE_OD;
  assign is_disable_cmd = ir_update.valid && ir_update.code == isp_ctrl_pkg::CMD_CONFIG_DISABLE;
  assign is_clear_cmd = ir_update.valid && ir_update.code == isp_ctrl_pkg::CMD_CONFIG_CLEAR;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_enabled_reg <= 1'b0;
      od_mode_reg <= 1'b0;
      disabled_reg <= 1'b0;
    end else if (port_abort || !test_on) begin
      cmd_enabled_reg <= 1'b0;
    end else if (is_enable_cmd) begin
      cmd_enabled_reg <= 1'b1;
      od_mode_reg <= is_od_cmd;
      disabled_reg <= 1'b0;
    end else if (is_disable_cmd) begin
      cmd_enabled_reg <= 1'b0;
      disabled_reg <= 1'b1;
    end
  end
  // flash failure wins over a clear arriving in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) error_reg <= 1'b0;
    else if (flash_error) error_reg <= 1'b1;
    else if (is_clear_cmd || (any_reset && disabled_reg)) error_reg <= 1'b0;
  end
  assign reg_hit = reg_addr == isp_ctrl_pkg::TEST_ENABLE_OFFSET;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) test_enable_reg <= isp_ctrl_pkg::TEST_ENABLE_RESET;
    else if (any_reset) test_enable_reg <= isp_ctrl_pkg::TEST_ENABLE_RESET;
    else if (reg_wr && reg_hit) test_enable_reg <= {7'h00, reg_wdata[0]};
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) reg_rdata <= 8'h00;
    else if (reg_rd) reg_rdata <= reg_hit ? test_enable_reg : 8'h00;
  end
  // recovery restarts while either reset is held
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) recovery_reg <= 16'(isp_ctrl_pkg::RECOVERY_CYCLES);
    else if (any_reset) recovery_reg <= 16'(isp_ctrl_pkg::RECOVERY_CYCLES);
    else if (recovery_reg != 16'h0000) recovery_reg <= recovery_reg - 16'h0001;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) eeblock_reg <= 32'(EEPROM_BLOCK_CYCLES);
    else if (eeblock_reg != 32'h0) eeblock_reg <= eeblock_reg - 32'h1;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      read_mode_reg <= 1'b1;
      memory_access_ok <= 1'b0;
      flash_write_go <= 1'b0;
      eeprom_strobe_out <= 1'b0;
      io_force_input <= 1'b1;
      logic_outputs_valid <= 1'b0;
      macrocell_state <= 8'h00;
      // power-on takes the configured map too, with the two forced bits cleared
      memory_map_register <= MAP_CONFIG_VALUE & ~isp_ctrl_pkg::MAP_CLEAR_MASK;
    end else begin
      read_mode_reg <= !(flash_busy || eeprom_busy);
      memory_access_ok <= !any_reset && recovery_reg == 16'h0000;
      flash_write_go <= flash_write_req && !supply_lockout && !any_reset;
      eeprom_strobe_out <= eeprom_write_strobe && eeblock_reg == 32'h0;
      io_force_input <= any_reset || recovery_reg != 16'h0000;
      logic_outputs_valid <= config_loaded || logic_outputs_valid;
      if (any_reset) begin
        macrocell_state <= macrocell_reset_value;
        memory_map_register <= MAP_CONFIG_VALUE & ~isp_ctrl_pkg::MAP_CLEAR_MASK;
      end
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      test_pins_dedicated <= 1'b0;
      tdo_out <= 1'b0;
      tdo_oe_n <= 1'b1;
      status_out <= 1'b1;
      status_oe_n <= 1'b1;
      error_out <= 1'b1;
      error_oe_n <= 1'b1;
    end else begin
      test_pins_dedicated <= test_on;
      tdo_out <= tdo_bit;
      tdo_oe_n <= !(cmd_enabled_reg && shift_active);
      status_out <= read_mode_reg && !(flash_busy || eeprom_busy);
      // open drain drives only a low level
      status_oe_n <= !cmd_enabled_reg || (od_mode_reg && read_mode_reg &&
                     !(flash_busy || eeprom_busy));
      error_out <= !error_reg;
      error_oe_n <= !cmd_enabled_reg || (od_mode_reg && !error_reg);
    end
  end
endmodule : reset_isp_ctrl
`default_nettype wire

// *** bench/reset_isp_ctrl_props.sv ***
`default_nettype none
module reset_isp_ctrl_props #(
  parameter int EEPROM_BLOCK_CYCLES = 50
) (
  // clock and resets
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic warm_reset_n,
  // device inputs
  input wire logic nvm_test_dedicate_bit,
  input wire logic part_blank,
  input wire logic test_select_term,
  input wire logic config_loaded,
  input wire logic supply_lockout,
  input wire logic flash_busy,
  input wire logic eeprom_busy,
  input wire logic flash_error,
  input wire logic [7:0] macrocell_reset_value,
  // device outputs
  input wire logic memory_access_ok,
  input wire logic flash_write_go,
  input wire logic eeprom_strobe_out,
  input wire logic io_force_input,
  input wire logic logic_outputs_valid,
  input wire logic test_pins_dedicated,
  input wire logic tdo_oe_n,
  input wire logic status_out,
  input wire logic status_oe_n,
  input wire logic error_out,
  input wire logic error_oe_n,
  input wire logic [7:0] macrocell_state
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // counters instead of long repetitions
  logic [7:0] low_cnt;
  int up_cnt;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      low_cnt <= 8'h00;
      up_cnt <= 0;
    end else begin
      low_cnt <= memory_access_ok ? 8'h00 : low_cnt + {7'h00, low_cnt != 8'hff};
      up_cnt <= (up_cnt < EEPROM_BLOCK_CYCLES) ? up_cnt + 1 : up_cnt;
    end
  end
  AST_RECOVERY: assert property ($rose(memory_access_ok) |-> low_cnt >= 8'h14)
    else $error("access before recovery");
  AST_WARM_ACCESS: assert property ((!warm_reset_n)[*5] |-> !memory_access_ok)
    else $error("access during warm reset");
  AST_WARM_IO: assert property ((!warm_reset_n)[*5] |-> io_force_input)
    else $error("io not input in reset");
  AST_WARM_MACRO: assert property ((!warm_reset_n)[*5] |->
    macrocell_state == macrocell_reset_value) else $error("macrocell state wrong");
  AST_WARM_LOGIC: assert property ((!warm_reset_n && config_loaded)[*5] |->
    logic_outputs_valid) else $error("logic outputs invalid");
  AST_LOCKOUT: assert property ($rose(flash_write_go) |-> !$past(supply_lockout))
    else $error("flash write under lockout");
  AST_EE_BLOCK: assert property (up_cnt < EEPROM_BLOCK_CYCLES - 1 |-> !eeprom_strobe_out)
    else $error("eeprom strobe too early");
  AST_PINS_ON: assert property ((nvm_test_dedicate_bit || test_select_term || part_blank)[*3]
    |-> test_pins_dedicated) else $error("test pins not dedicated");
  AST_TDO_OFF: assert property ((!test_pins_dedicated)[*2] |-> tdo_oe_n)
    else $error("tdo driven while off");
  AST_STATUS_BUSY: assert property ((flash_busy || eeprom_busy)[*3] |->
    status_oe_n || !status_out) else $error("status high while busy");
  AST_ERROR_SET: assert property (flash_error |-> ##[1:3] (error_oe_n || !error_out))
    else $error("error pin not low");
  cover property ($rose(memory_access_ok));
  cover property (!status_oe_n && !status_out);
  cover property (!error_oe_n && !error_out);
endmodule : reset_isp_ctrl_props
`default_nettype wire

// *** bench/test_cable_model.sv ***
`default_nettype none
module test_cable_model (
  // serial test pins
  output logic tck_pin,
  output logic tms_pin,
  output logic tdi_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // clock parks low between frames
  initial begin
    tck_pin = 1'b0;
    tms_pin = 1'b1;
    tdi_pin = 1'b0;
  end
  task automatic step(input logic m, input logic d);
    tms_pin = m;
    tdi_pin = d;
    #40 tck_pin = 1'b1;
    #40 tck_pin = 1'b0;
  endtask : step
  task automatic send_ir(input logic [7:0] code);
    int i;
    for (i = 0; i < 5; i++) step(1'b1, 1'b0);
    for (i = 0; i < 5; i++) step(i[0] ^ i[1], 1'b0);
    for (i = 0; i < 8; i++) step(i == 7, code[i]);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    // idle data must not look like the last bit
    tdi_pin = ~code[7];
  endtask : send_ir
endmodule : test_cable_model
`default_nettype wire

// *** bench/tb.sv ***
`default_nettype none
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, rst, warm_reset_n, nvm_test_dedicate_bit, part_blank, config_loaded;
  logic supply_lockout, test_select_term, flash_write_req, eeprom_write_strobe, flash_busy;
  logic eeprom_busy, flash_error, reg_wr, reg_rd, tck_pin, tms_pin, tdi_pin, tdo_out;
  logic tdo_oe_n, status_out, status_oe_n, error_out, error_oe_n, memory_access_ok;
  logic flash_write_go, eeprom_strobe_out, io_force_input, logic_outputs_valid;
  logic test_pins_dedicated;
  logic [7:0] macrocell_reset_value, reg_addr, reg_wdata, reg_rdata, macrocell_state;
  logic [7:0] memory_map_register;
  int fails, samples_checked, n, cycles;
  test_cable_model cable (.*);
  reset_isp_ctrl #(.EEPROM_BLOCK_CYCLES(50), .MAP_CONFIG_VALUE(8'hff)) dut (.*);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic stop_test;
    if (fails == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask : rd
  task automatic wait_ok(input int lo, input int hi);
    n = 0;
    while (memory_access_ok !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    `CHK(n >= lo && n <= hi, 1'b1)
  endtask : wait_ok
  task automatic t_power_up;
    #1 `CHK({io_force_input, memory_access_ok, tdo_oe_n, macrocell_state}, 11'h500)
    `CHK({memory_map_register, logic_outputs_valid}, 9'h1f8)
    wait_ok(20, 25);
    @(posedge clk_sys);
    config_loaded <= 1'b1;
    eeprom_write_strobe <= 1'b1;
    cyc(3);
    `CHK({logic_outputs_valid, eeprom_strobe_out}, 2'h2)
    cyc(30);
    `CHK(eeprom_strobe_out, 1'b1)
    rd(8'hc7, 8'h00);
  endtask : t_power_up
  task automatic t_lockout;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      supply_lockout <= (i == 0);
      flash_write_req <= 1'b1;
      cyc(4);
      `CHK(flash_write_go, i[0])
    end
  endtask : t_lockout
  task automatic t_enable;
    wr(8'hc7, 8'hff);
    rd(8'hc7, 8'h01);
    rd(8'h10, 8'h00);
    `CHK(test_pins_dedicated, 1'b1)
    wr(8'hc7, 8'h00);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      {nvm_test_dedicate_bit, test_select_term, part_blank} <= 3'h4 >> i;
      cyc(4);
      `CHK(test_pins_dedicated, i < 3)
    end
  endtask : t_enable
  task automatic t_isp;
    wr(8'hc7, 8'h01);
    cyc(3);
    `CHK({tdo_oe_n, status_oe_n}, 2'h3)
    cable.send_ir(isp_ctrl_pkg::CMD_CONFIG_ENABLE);
    cyc(4);
    `CHK({status_oe_n, status_out, error_out}, 3'h3)
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      {flash_busy, eeprom_busy} <= 2'h2 >> i;
      cyc(4);
      `CHK(status_out, i == 2)
    end
    @(posedge clk_sys);
    flash_error <= 1'b1;
    @(posedge clk_sys);
    flash_error <= 1'b0;
    cyc(3);
    `CHK(error_out, 1'b0)
    cable.send_ir(isp_ctrl_pkg::CMD_CONFIG_CLEAR);
    cyc(4);
    `CHK(error_out, 1'b1)
    cable.send_ir(isp_ctrl_pkg::CMD_CONFIG_ENABLE_OD);
    cyc(4);
    `CHK({status_oe_n, error_oe_n}, 2'h3)
  endtask : t_isp
  task automatic t_warm(input logic nv);
    @(posedge clk_sys);
    nvm_test_dedicate_bit <= nv;
    wr(8'hc7, 8'h01);
    cable.send_ir(isp_ctrl_pkg::CMD_CONFIG_ENABLE);
    if (!nv) begin
      @(posedge clk_sys);
      flash_error <= 1'b1;
      @(posedge clk_sys);
      flash_error <= 1'b0;
      cable.send_ir(isp_ctrl_pkg::CMD_CONFIG_DISABLE);
      cyc(4);
      `CHK(error_out, 1'b0)
    end
    @(posedge clk_sys);
    warm_reset_n <= 1'b0;
    cyc(6);
    `CHK({io_force_input, memory_access_ok, logic_outputs_valid}, 3'h5)
    `CHK(macrocell_state, macrocell_reset_value)
    @(posedge clk_sys);
    warm_reset_n <= 1'b1;
    wait_ok(20, 28);
    rd(8'hc7, 8'h00);
    `CHK({status_oe_n, test_pins_dedicated}, {~nv, nv})
    `CHK(error_out, 1'b1)
  endtask : t_warm
  initial begin
    rst = 1'b1;
    warm_reset_n = 1'b1;
    {nvm_test_dedicate_bit, part_blank, config_loaded, supply_lockout, test_select_term} = '0;
    {flash_write_req, eeprom_write_strobe, flash_busy, eeprom_busy, flash_error} = '0;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    macrocell_reset_value = 8'h5a;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_power_up();
    t_lockout();
    t_enable();
    t_isp();
    t_warm(1'b0);
    t_warm(1'b1);
    stop_test();
  end
endmodule : tb
bind reset_isp_ctrl reset_isp_ctrl_props #(.EEPROM_BLOCK_CYCLES(EEPROM_BLOCK_CYCLES)) props (.*);
`default_nettype wire
